/* hw/crsbo_channel.sv */
`timescale 1ns/1ps
`default_nettype none
module crsbo_channel #(
  parameter bit HAS_ASM = 1'b1
) (
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  input  wire logic                          store_req,
  input  wire logic                          load_req,
  input  wire logic [crsbo_pkg::SEL_W-1:0]   io_designator,
  input  wire logic [crsbo_pkg::ERO_W-1:0]   extended_output_path,
  output logic      [crsbo_pkg::ERO_W-1:0]   extended_input_path,
  output logic                               load_valid,
  input  wire logic                          rank_transfer_strobe,
  input  wire logic                          hw_transfer_active,
  input  wire logic                          byte_done,
  input  wire logic [crsbo_pkg::ERO_W-1:0]   incoming_bus_word,
  input  wire logic [crsbo_pkg::TAGIN_W-1:0] tag_in_lines,
  output logic      [crsbo_pkg::BYTE_W-1:0]  bus_out_lines,
  output logic                               bus_out_parity,
  output logic      [crsbo_pkg::BYTE_W-1:0]  outgoing_tag_register,
  output logic      [crsbo_pkg::BYTE_W-1:0]  channel_control_register,
  output logic      [crsbo_pkg::COUNT_W-1:0] transfer_byte_counter,
  output logic                               high_byte_enable
);

  localparam int BW = crsbo_pkg::BYTE_W;
  localparam int WW = crsbo_pkg::ERO_W;

  // path naming: the low half of the word carries path bits 8-15,
  // the high half bits 0-7, so byte one is always [7:0]
  logic [BW-1:0] store_odd_byte;
  logic [BW-1:0] store_even_byte;
  assign store_odd_byte  = extended_output_path[BW-1:0];
  assign store_even_byte = extended_output_path[WW-1:BW];

  // the designator passes through unchanged as the select bits
  logic [crsbo_pkg::SEL_W-1:0] group_three_select_bits;
  assign group_three_select_bits = io_designator;

  crsbo_pkg::crsbo_req_t req;
  assign req = '{store: store_req, load: load_req, sel: group_three_select_bits};

  // one write enable per select bit; several may be set at once, so a
  // single store loads every selected register from the same path value
  logic [crsbo_pkg::SEL_W-1:0] write_en;
  for (genvar g = 0; g < crsbo_pkg::SEL_W; g++)
  begin : g_write_en
    assign write_en[g] = req.store && req.sel[g];
  end

  logic [crsbo_pkg::ERO_W-1:0] outgoing_first_rank;
  logic [crsbo_pkg::ERO_W-1:0] outgoing_second_rank;
  logic [crsbo_pkg::ERO_W-1:0] incoming_bus_byte;
  logic                        asm_mode;
  logic                        alternate;
  logic [BW-1:0]               sel_byte;
  crsbo_pkg::crsbo_lines_t     lines_next;

  // mode flip-flop exists only when the option is fitted
  assign asm_mode  = HAS_ASM && channel_control_register[crsbo_pkg::CCR_MODE_BIT];
  assign alternate = asm_mode && hw_transfer_active;

  // tag register holds the inverted low-order path byte
  always_ff @(posedge core_clk)
  begin
    if (rst)
      outgoing_tag_register <= crsbo_pkg::TAG_RESET;
    else if (write_en[crsbo_pkg::SEL_TAG])
      outgoing_tag_register <= ~store_odd_byte;
  end

  // channel control register; mode bit masked when option absent
  always_ff @(posedge core_clk)
  begin
    if (rst)
      channel_control_register <= crsbo_pkg::CCR_RESET;
    else if (write_en[crsbo_pkg::SEL_CTRL])
    begin
      channel_control_register <= store_odd_byte;
      if (!HAS_ASM)
        channel_control_register[crsbo_pkg::CCR_MODE_BIT] <= 1'b0;
    end
  end

  // byte counter is written whole from the sixteen-bit path
  always_ff @(posedge core_clk)
  begin
    if (rst)
      transfer_byte_counter <= crsbo_pkg::COUNT_RESET;
    else if (write_en[crsbo_pkg::SEL_COUNT])
      transfer_byte_counter <= extended_output_path;
  end

  // first rank, odd half: path bits 8-15 on every bus-out write
  logic [BW-1:0] first_rank_odd;
  logic [BW-1:0] first_rank_even;
  always_ff @(posedge core_clk)
  begin
    if (rst)
      first_rank_odd <= crsbo_pkg::BUS_RESET[BW-1:0];
    else if (write_en[crsbo_pkg::SEL_BUS])
      first_rank_odd <= store_odd_byte;
  end

  // first rank, even half: only fitted with the option; without it the
  // half stays zero so a later mode change cannot expose stale data
  always_ff @(posedge core_clk)
  begin
    if (rst)
      first_rank_even <= crsbo_pkg::BUS_RESET[WW-1:BW];
    else if (write_en[crsbo_pkg::SEL_BUS])
      first_rank_even <= HAS_ASM ? store_even_byte : '0;
  end

  // both halves share one enable and move to the second rank together
  assign outgoing_first_rank = {first_rank_even, first_rank_odd};

  // second rank moves only on the strobe from channel control
  always_ff @(posedge core_clk)
  begin
    if (rst)
      outgoing_second_rank <= crsbo_pkg::BUS_RESET;
    else if (rank_transfer_strobe)
      outgoing_second_rank <= outgoing_first_rank;
  end

  // second-rank bus-in is taken as supplied by the receive side; without the option its high half loads zero
  always_ff @(posedge core_clk)
  begin
    if (rst)
      incoming_bus_byte <= crsbo_pkg::BUS_RESET;
    else if (rank_transfer_strobe)
      incoming_bus_byte <= HAS_ASM ? incoming_bus_word : {{BW{1'b0}}, incoming_bus_word[BW-1:0]};
  end

  // high-byte flip-flop; path bits 8-15 sit in the low half of the word
  always_ff @(posedge core_clk)
  begin
    if (rst)
      high_byte_enable <= 1'b1;
    else if (!alternate)
      high_byte_enable <= 1'b1;
    else if (byte_done)
      high_byte_enable <= ~high_byte_enable;
  end

  // half selector: the low half is the odd byte and is the only one used
  // unless the option is fitted; both halves never reach the lines together
  logic [BW-1:0] low_half;
  logic [BW-1:0] high_half;
  assign low_half  = outgoing_second_rank[BW-1:0];
  assign high_half = outgoing_second_rank[WW-1:BW];

  always_comb
  begin
    if (high_byte_enable || !HAS_ASM)
      sel_byte = low_half;
    else
      sel_byte = high_half;
  end

  // lines are driven through a rank of inverters
  always_comb
  begin
    lines_next.data   = ~sel_byte;
    // odd count of ones across eight lines plus parity
    lines_next.parity = ~(^lines_next.data);
  end

  // registered line drivers add one cycle after the second rank moves;
  // reset shows all ones, the image of a cleared second rank
  always_ff @(posedge core_clk)
  begin
    if (rst)
      bus_out_lines <= {BW{1'b1}};
    else
      bus_out_lines <= lines_next.data;
  end

  // parity driver registered with the lines so both change together
  always_ff @(posedge core_clk)
  begin
    if (rst)
      bus_out_parity <= 1'b1;
    else
      bus_out_parity <= lines_next.parity;
  end

  // byte one multiplexer: feeds input path bits 8-15, the low half here
  logic [BW-1:0] byte_one_mux;
  // byte zero multiplexer: feeds input path bits 0-7, the high half here
  logic [BW-1:0] byte_zero_mux;
  // load source code sits on select bits 02 and 03; bits 00 and 01 are
  // ignored, so a load never needs a clean upper designator
  logic [1:0]    load_src;
  assign load_src = req.sel[crsbo_pkg::SEL_CTRL:crsbo_pkg::SEL_TAG];

  always_comb
  begin
    case (load_src)
      crsbo_pkg::SRC_BUS_IN: byte_one_mux = incoming_bus_byte[BW-1:0];
      crsbo_pkg::SRC_TAG:    byte_one_mux = outgoing_tag_register;
      crsbo_pkg::SRC_CTRL:   byte_one_mux = channel_control_register;
      crsbo_pkg::SRC_COUNT:  byte_one_mux = transfer_byte_counter[BW-1:0];
      default:               byte_one_mux = '0;
    endcase
  end

  // high half of bus-in only carries data while assembling; otherwise it
  // reads zero so plain byte mode looks like a channel without the option
  always_comb
  begin
    case (load_src)
      crsbo_pkg::SRC_BUS_IN: byte_zero_mux = asm_mode ? incoming_bus_byte[WW-1:BW] : '0;
      crsbo_pkg::SRC_TAG:    byte_zero_mux = tag_in_lines;
      crsbo_pkg::SRC_CTRL:   byte_zero_mux = '0;
      crsbo_pkg::SRC_COUNT:  byte_zero_mux = transfer_byte_counter[WW-1:BW];
      default:               byte_zero_mux = '0;
    endcase
  end

  // load valid marks the one cycle in which the returned word is new
  always_ff @(posedge core_clk)
  begin
    if (rst)
      load_valid <= 1'b0;
    else
      load_valid <= req.load;
  end

  // load data register: holds the last returned word until the next load
  always_ff @(posedge core_clk)
  begin
    if (rst)
      extended_input_path <= '0;
    else if (req.load)
      extended_input_path <= {byte_zero_mux, byte_one_mux};
  end

endmodule : crsbo_channel
`default_nettype wire

/* hw/crsbo_pkg.sv */
package crsbo_pkg;
  // select bit positions, bit 00 is the msb of the 4-bit designator
  localparam int SEL_W        = 4;
  localparam int SEL_TAG      = 0; // designator bit 03
  localparam int SEL_CTRL     = 1; // designator bit 02
  localparam int SEL_BUS      = 2; // designator bit 01
  localparam int SEL_COUNT    = 3; // designator bit 00
  localparam int ERO_W        = 16;
  localparam int BYTE_W       = 8;
  localparam int COUNT_W      = 16;
  localparam int TAGIN_W      = 8;
  // load source codes on select bits 02 and 03
  localparam logic [1:0] SRC_BUS_IN  = 2'h0;
  localparam logic [1:0] SRC_TAG     = 2'h1;
  localparam logic [1:0] SRC_CTRL    = 2'h2;
  localparam logic [1:0] SRC_COUNT   = 2'h3;
  // channel control field positions
  localparam int CCR_MODE_BIT = 0;
  localparam logic [BYTE_W-1:0]  CCR_RESET   = 8'h00;
  localparam logic [BYTE_W-1:0]  TAG_RESET   = 8'hff; // inverted store of zero
  localparam logic [ERO_W-1:0]   BUS_RESET   = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;

  typedef struct packed {
    logic             store;
    logic             load;
    logic [SEL_W-1:0] sel;
  } crsbo_req_t;

  typedef struct packed {
    logic [BYTE_W-1:0] data;
    logic              parity;
  } crsbo_lines_t;
endpackage : crsbo_pkg

/* test/crsbo_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
// far-end adapter: echoes the bus-out byte as bus-in data and answers tag-out
module crsbo_far_end (
  input  wire logic [7:0]  bus_out_lines,
  input  wire logic [7:0]  outgoing_tag_register,
  output logic      [15:0] incoming_bus_word,
  output logic      [7:0]  tag_in_lines
);
  // wire is inverted, so the echo differs per half to expose a swapped byte
  assign incoming_bus_word = {bus_out_lines, ~bus_out_lines};
  assign tag_in_lines = ~outgoing_tag_register;
endmodule : crsbo_far_end
`default_nettype wire

/* test/crsbo_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module crsbo_asserts #(parameter bit HAS_ASM = 1'b1) (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        store_req,
  input wire logic        load_req,
  input wire logic [3:0]  io_designator,
  input wire logic [15:0] extended_output_path,
  input wire logic [15:0] extended_input_path,
  input wire logic        load_valid,
  input wire logic        rank_transfer_strobe,
  input wire logic        hw_transfer_active,
  input wire logic        byte_done,
  input wire logic [7:0]  tag_in_lines,
  input wire logic [7:0]  bus_out_lines,
  input wire logic        bus_out_parity,
  input wire logic [7:0]  outgoing_tag_register,
  input wire logic [7:0]  channel_control_register,
  input wire logic [15:0] transfer_byte_counter,
  input wire logic        high_byte_enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // byte stored, then ranked over while plain mode is held
  sequence s_bus;
    store_req && io_designator[2] && !io_designator[1] && !channel_control_register[0] ##1
      rank_transfer_strobe && !store_req;
  endsequence
  property p_bus; s_bus |=> ##1 bus_out_lines == ~$past(extended_output_path[7:0], 3); endproperty
  property p_tag; store_req && io_designator[0] |=> outgoing_tag_register == ~$past(extended_output_path[7:0]);
  endproperty
  property p_cnt; store_req && io_designator[3] |=> transfer_byte_counter == $past(extended_output_path); endproperty
  property p_lv; load_valid == $past(load_req); endproperty
  property p_ldt; load_req && io_designator[1:0] == 2'h1 |=>
    extended_input_path == {$past(tag_in_lines), $past(outgoing_tag_register)}; endproperty
  property p_par; ^{bus_out_lines, bus_out_parity}; endproperty
  property p_tog; hw_transfer_active && byte_done && channel_control_register[0] && HAS_ASM |=>
    high_byte_enable != $past(high_byte_enable); endproperty
  property p_plain; !hw_transfer_active || !channel_control_register[0] |=> high_byte_enable; endproperty
  a_bus: assert property (p_bus) else $error("bus-out byte");
  a_tag: assert property (p_tag) else $error("tag register");
  a_cnt: assert property (p_cnt) else $error("counter");
  a_lv: assert property (p_lv) else $error("load valid");
  a_ldt: assert property (p_ldt) else $error("tag load");
  a_par: assert property (p_par) else $error("parity");
  a_tog: assert property (p_tog) else $error("no toggle");
  a_plain: assert property (p_plain) else $error("byte select");
endmodule : crsbo_asserts
bind crsbo_channel crsbo_asserts #(.HAS_ASM(HAS_ASM)) u_asserts (.*);
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0, rst = 1'b1, store_req = 1'b0, load_req = 1'b0, rank_transfer_strobe = 1'b0;
  logic hw_transfer_active = 1'b0, byte_done = 1'b0, load_valid, bus_out_parity, high_byte_enable;
  logic [3:0] io_designator = 4'h0;
  logic [7:0] tag_in_lines, bus_out_lines, outgoing_tag_register, channel_control_register;
  logic [15:0] extended_output_path = 16'h0000, extended_input_path, incoming_bus_word, transfer_byte_counter;
  logic [15:0] lf = 16'h0dc5;
  int err_total = 0, n_checks = 0, m_tor = 255, m_ccr = 0, m_b1 = 0, m_b2 = 0, m_cnt = 0, m_bir = 0, m_hbe = 1;
  crsbo_channel DUT (.*);
  crsbo_far_end far (.*);
  initial forever #12.5 core_clk = ~core_clk;
  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : nxt
  task automatic chk(input logic [15:0] got, input int exp);
    n_checks++;
    if (got !== exp[15:0])
    begin
      err_total++;
      $display("wrong value at %0t: %h not %h", $time, got, exp[15:0]);
    end
  endtask : chk
  // lines carry the inverted selected half; parity makes nine lines odd
  task automatic chk_bus();
    logic [7:0] eb;
    eb = 8'(~(m_b2 >> (m_hbe != 0 ? 0 : 8)));
    chk({7'h00, bus_out_parity, bus_out_lines}, {7'h00, ~^eb, eb});
  endtask : chk_bus
  task automatic regs();
    chk(outgoing_tag_register, m_tor);
    chk(channel_control_register, m_ccr);
    chk(transfer_byte_counter, m_cnt);
  endtask : regs
  // one cycle: drive at the falling edge, check, then advance the model
  task automatic step(input logic s, l, t, d, input logic [3:0] k, input logic [15:0] w);
    int e;
    {store_req, load_req, rank_transfer_strobe, byte_done, io_designator, extended_output_path} = {s, l, t, d, k, w};
    e = k[1:0] == 2'h0 ? (m_ccr % 2 == 1 ? m_bir : m_bir & 255)
      : k[1:0] == 2'h1 ? tag_in_lines * 256 + m_tor : k[1:0] == 2'h2 ? m_ccr : m_cnt;
    if (t) m_bir = incoming_bus_word;
    @(negedge core_clk);
    if (l) chk(extended_input_path, e);
    if (!hw_transfer_active || m_ccr % 2 == 0) m_hbe = 1;
    else if (d) m_hbe ^= 1;
    if (t) m_b2 = m_b1;
    if (s && k[0]) m_tor = ~w & 255;
    if (s && k[1]) m_ccr = w & 255;
    if (s && k[2]) m_b1 = w;
    if (s && k[3]) m_cnt = w;
  endtask : step
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  // main sequence: reset, select decoding, ranking, byte alternation
  initial
  begin
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    regs();
    chk_bus();
    $display("reset test done");
    for (int i = 0; i < 16; i++)
    begin
      lf = nxt(lf);
      step(1'b1, lf[4], 1'b0, 1'b0, i[3:0], lf);
      regs();
      for (int j = 0; j < 4; j++) step(1'b0, 1'b1, 1'b0, 1'b0, {lf[3:2], j[1:0]}, lf);
    end
    $display("select test done");
    step(1'b1, 1'b0, 1'b0, 1'b0, 4'h2, 16'h0000);
    step(1'b1, 1'b0, 1'b0, 1'b0, 4'h4, 16'h00a5);
    step(1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 16'h0000);
    chk_bus();
    step(1'b0, 1'b0, 1'b1, 1'b0, 4'h4, 16'h1234);
    step(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 16'h0000);
    chk_bus();
    step(1'b1, 1'b0, 1'b0, 1'b0, 4'h4, 16'h003c);
    step(1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 16'h0000);
    step(1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 16'h0000);
    chk_bus();
    step(1'b1, 1'b0, 1'b0, 1'b0, 4'h6, 16'h5c01);
    step(1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 16'h0000);
    step(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 16'h0000);
    hw_transfer_active = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      step(1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 16'h0000);
      step(1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 16'h0000);
      chk_bus();
    end
    hw_transfer_active = 1'b0;
    step(1'b1, 1'b0, 1'b0, 1'b0, 4'h2, 16'h0000);
    step(1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 16'h0000);
    chk_bus();
    hw_transfer_active = 1'b1;
    step(1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 16'h0000);
    step(1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 16'h0000);
    chk_bus();
    $display("bus-out test done");
    close_out();
  end
  // watchdog: the run needs about 3 us
  initial
  begin
    #20000;
    err_total++;
    close_out();
  end
endmodule : tb_top
`default_nettype wire
